/* rail_strobe_pkg.sv */
// Constants for the rail strobe assignment registers
package rail_strobe_pkg;

  // ==========================================================
  // Register subaddresses and reset values
  localparam logic [7:0] ADDR_BACKUP   = 8'h24;
  localparam logic [7:0] ADDR_SW_LDO   = 8'h25;
  localparam logic [7:0] ADDR_GPO      = 8'h26;
  localparam logic [7:0] RST_BACKUP    = 8'h12;
  localparam logic [7:0] RST_SW_LDO    = 8'ha7;
  localparam logic [7:0] RST_GPO       = 8'h35;
  localparam logic [7:0] BACKUP_MASK   = 8'h33;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int         B1V8_LSB      = 4;
  localparam int         B1V0_LSB      = 0;
  localparam int         SWITCH_LSB    = 4;
  localparam int         LINREG_LSB    = 0;
  localparam int         PAIR_W        = 2;
  localparam int         NIB_W         = 4;

  // ==========================================================
  // Strobe numbers and rail slots
  localparam logic [3:0] STROBE_NONE   = 4'h0;
  localparam logic [3:0] STROBE_ONE    = 4'h1;
  localparam logic [3:0] STROBE_TWO    = 4'h2;
  localparam logic [3:0] STROBE_MIN    = 4'h3;
  localparam logic [3:0] STROBE_MAX    = 4'ha;
  localparam int         RAIL_B1V8     = 0;
  localparam int         RAIL_B1V0     = 1;
  localparam int         RAIL_SWITCH   = 2;
  localparam int         RAIL_LINREG   = 3;
  localparam int         NUM_RAILS     = 4;

  // ==========================================================
  // Field decoding: strobe number, or STROBE_NONE when not sequenced
  function automatic logic [3:0] strobeOfPair(input logic [1:0] code);
    logic [3:0] wide;
    wide = {2'h0, code};
    strobeOfPair = (wide == STROBE_ONE || wide == STROBE_TWO) ? wide : STROBE_NONE;
  endfunction : strobeOfPair

  function automatic logic [3:0] strobeOfNibble(input logic [3:0] code);
    strobeOfNibble = (code >= STROBE_MIN && code <= STROBE_MAX) ? code : STROBE_NONE;
  endfunction : strobeOfNibble

endpackage : rail_strobe_pkg

/* rail_enable_cell.sv */
// One rail's enable flop, driven by the strobes that hit it
`timescale 1ns/1ps
module rail_enable_cell (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic strobeHit,
  input  wire logic powerDown,
  input  wire logic holdOn,
  output logic      railEn
);

  logic railEn_ff;
  logic nxt_railEn;

  always_comb begin
    nxt_railEn = railEn_ff;
    if (strobeHit) begin
      if (!powerDown) begin
        nxt_railEn = 1'b1;
      end else if (!holdOn) begin
        nxt_railEn = 1'b0; // Backup rails pass holdOn once the seal is gone
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      railEn_ff <= 1'b0;
    end else begin
      railEn_ff <= nxt_railEn;
    end
  end

  assign railEn = railEn_ff;

endmodule : rail_enable_cell

/* rail_strobe_assignment_regs.sv */
// Rail strobe assignment registers and strobe gating of the power sequencer
// Summary of operation
// - 1.8 V backup buck field bits 5-4: 1 strobe 1, 2 strobe 2, reset 1.
// - 1.0 V backup buck field bits 1-0, same coding, reset value 2.
// - Strobes 1 and 2 are executed only while the seal flag is zero.
// - Once the seal is broken, power-down never turns off either backup buck.
// - Switch bits 7-4 and regulator bits 3-0: codes 3 to A mean strobes 3-10.
// - Other nibble codes leave the rail untouched by the sequencer.
// - Switch/regulator register at 0x25 resets to 0xa7.
// - General-purpose output register at 0x26 resets to 0x35.
// - Backup register at 0x24 resets to 0x12, reserved bits read zero.
`timescale 1ns/1ps
module rail_strobe_assignment_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic       unlockOk,
  output logic      [7:0] regRdData,
  output logic            regWrRejected,
  input  wire logic       freshnessSealFlag,
  input  wire logic       strobeFire,
  input  wire logic [3:0] strobeIdx,
  input  wire logic       powerDown,
  output logic      [3:0] railEn,
  output logic            strobeDone,
  output logic            strobeSkipped,
  output logic      [1:0] backup1v8StrobeSel,
  output logic      [1:0] backup1v0StrobeSel,
  output logic      [3:0] lvSwitchStrobeSel,
  output logic      [3:0] linearRegStrobeSel,
  output logic      [7:0] gpOutputStrobeSelect
);

  // ==========================================================
  // Register file
  logic [7:0] backup_ff;
  logic [7:0] swLdo_ff;
  logic [7:0] gpo_ff;
  logic [7:0] rdData_ff;
  logic       wrRej_ff;
  logic [7:0] nxt_backup;
  logic [7:0] nxt_swLdo;
  logic [7:0] nxt_gpo;
  logic [7:0] nxt_rdData;
  logic       nxt_wrRej;
  logic       addrHit;

  always_comb begin
    nxt_backup = backup_ff;
    nxt_swLdo  = swLdo_ff;
    nxt_gpo    = gpo_ff;
    nxt_rdData = rdData_ff;
    addrHit    = (regAddr == rail_strobe_pkg::ADDR_BACKUP) ||
                 (regAddr == rail_strobe_pkg::ADDR_SW_LDO) ||
                 (regAddr == rail_strobe_pkg::ADDR_GPO);
    // Locked writes to the three mapped registers are dropped but flagged, so software can tell
    nxt_wrRej  = regWrEn && !unlockOk && addrHit;
    if (regWrEn && unlockOk) begin
      case (regAddr)
        rail_strobe_pkg::ADDR_BACKUP: begin
          nxt_backup = regWrData & rail_strobe_pkg::BACKUP_MASK;
        end
        rail_strobe_pkg::ADDR_SW_LDO: begin
          nxt_swLdo = regWrData;
        end
        rail_strobe_pkg::ADDR_GPO: begin
          nxt_gpo = regWrData;
        end
        default: begin
        end
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        rail_strobe_pkg::ADDR_BACKUP: nxt_rdData = backup_ff & rail_strobe_pkg::BACKUP_MASK;
        rail_strobe_pkg::ADDR_SW_LDO: nxt_rdData = swLdo_ff;
        rail_strobe_pkg::ADDR_GPO:    nxt_rdData = gpo_ff;
        default:                      nxt_rdData = rail_strobe_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      backup_ff <= rail_strobe_pkg::RST_BACKUP;
      swLdo_ff  <= rail_strobe_pkg::RST_SW_LDO;
      gpo_ff    <= rail_strobe_pkg::RST_GPO;
      rdData_ff <= rail_strobe_pkg::RD_UNMAPPED;
      wrRej_ff  <= 1'b0;
    end else begin
      backup_ff <= nxt_backup;
      swLdo_ff  <= nxt_swLdo;
      gpo_ff    <= nxt_gpo;
      rdData_ff <= nxt_rdData;
      wrRej_ff  <= nxt_wrRej;
    end
  end

  assign regRdData            = rdData_ff;
  assign regWrRejected        = wrRej_ff;
  assign backup1v8StrobeSel   = backup_ff[rail_strobe_pkg::B1V8_LSB +: rail_strobe_pkg::PAIR_W];
  assign backup1v0StrobeSel   = backup_ff[rail_strobe_pkg::B1V0_LSB +: rail_strobe_pkg::PAIR_W];
  assign lvSwitchStrobeSel    = swLdo_ff[rail_strobe_pkg::SWITCH_LSB +: rail_strobe_pkg::NIB_W];
  assign linearRegStrobeSel   = swLdo_ff[rail_strobe_pkg::LINREG_LSB +: rail_strobe_pkg::NIB_W];
  assign gpOutputStrobeSelect = gpo_ff;

  // ==========================================================
  // Seal flag synchroniser: the flag comes from the always-on domain
  logic sealMeta_ff;
  logic sealSync_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sealMeta_ff <= 1'b0;
      sealSync_ff <= 1'b0;
    end else begin
      sealMeta_ff <= freshnessSealFlag;
      sealSync_ff <= sealMeta_ff;
    end
  end

  // ==========================================================
  // Strobe gating and rail matching
  logic [3:0] railStrobe [rail_strobe_pkg::NUM_RAILS];
  logic       sealStrobe;
  logic       fireOk;
  logic       doneNow;
  logic       skipNow;
  logic       strobeDone_ff;
  logic       strobeSkipped_ff;
  logic [rail_strobe_pkg::NUM_RAILS-1:0] railHit;
  logic [rail_strobe_pkg::NUM_RAILS-1:0] railHold;

  always_comb begin
    railStrobe[rail_strobe_pkg::RAIL_B1V8]   = rail_strobe_pkg::strobeOfPair(backup1v8StrobeSel);
    railStrobe[rail_strobe_pkg::RAIL_B1V0]   = rail_strobe_pkg::strobeOfPair(backup1v0StrobeSel);
    railStrobe[rail_strobe_pkg::RAIL_SWITCH] = rail_strobe_pkg::strobeOfNibble(lvSwitchStrobeSel);
    railStrobe[rail_strobe_pkg::RAIL_LINREG] = rail_strobe_pkg::strobeOfNibble(linearRegStrobeSel);
    sealStrobe = (strobeIdx == rail_strobe_pkg::STROBE_ONE) ||
                 (strobeIdx == rail_strobe_pkg::STROBE_TWO);
    skipNow    = strobeFire && sealStrobe && sealSync_ff;
    fireOk     = strobeFire && !skipNow;
    doneNow    = fireOk;
    for (int i = 0; i < rail_strobe_pkg::NUM_RAILS; i++) begin
      // STROBE_NONE never equals a live index, so unsequenced rails stay put
      railHit[i] = fireOk && (railStrobe[i] != rail_strobe_pkg::STROBE_NONE) &&
                   (railStrobe[i] == strobeIdx);
    end
    railHold                          = '0;
    railHold[rail_strobe_pkg::RAIL_B1V8] = sealSync_ff;
    railHold[rail_strobe_pkg::RAIL_B1V0] = sealSync_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strobeDone_ff    <= 1'b0;
      strobeSkipped_ff <= 1'b0;
    end else begin
      strobeDone_ff    <= doneNow;
      strobeSkipped_ff <= skipNow;
    end
  end

  assign strobeDone    = strobeDone_ff;
  assign strobeSkipped = strobeSkipped_ff;

  for (genvar g = 0; g < rail_strobe_pkg::NUM_RAILS; g++) begin : gRail
    rail_enable_cell uCell (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .strobeHit (railHit[g]),
      .powerDown (powerDown),
      .holdOn    (railHold[g]),
      .railEn    (railEn[g])
    );
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_values: assert property ($past(sys_rst) |-> backup_ff == 8'h12 &&
      swLdo_ff == 8'ha7 && gpo_ff == 8'h35)
    else $error("register reset values wrong");
  a_backup_rsvd_zero: assert property (regRdEn && regAddr == 8'h24 |=>
      regRdData[7:6] == 2'h0 && regRdData[3:2] == 2'h0)
    else $error("backup reserved bits not zero");
  a_locked_write_drop: assert property (regWrEn && !unlockOk |=>
      $stable(backup_ff) && $stable(swLdo_ff) && $stable(gpo_ff) &&
      regWrRejected == $past(addrHit))
    else $error("locked write changed a register");
  a_swldo_write: assert property (regWrEn && unlockOk && regAddr == 8'h25 |=>
      swLdo_ff == $past(regWrData))
    else $error("switch register write lost");
  // The host leaves one idle cycle between a write and the following read
  a_gpo_write_read: assert property (regWrEn && unlockOk && regAddr == 8'h26 ##1
      !regWrEn ##1 regRdEn && regAddr == 8'h26 && !regWrEn |=>
      regRdData == $past(regWrData, 3))
    else $error("gpo readback wrong");
  a_seal_skip: assert property (strobeFire && sealSync_ff &&
      (strobeIdx == 4'h1 || strobeIdx == 4'h2) |=> strobeSkipped && !strobeDone && $stable(railEn))
    else $error("sealed strobe not skipped");
  a_b1v8_strobe1: assert property (strobeFire && !sealSync_ff && !powerDown &&
      strobeIdx == 4'h1 && backup1v8StrobeSel == 2'h1 |=> railEn[0])
    else $error("1v8 buck missed strobe 1");
  a_b1v0_strobe2: assert property (strobeFire && !sealSync_ff && !powerDown &&
      strobeIdx == 4'h2 && backup1v0StrobeSel == 2'h2 |=> railEn[1])
    else $error("1v0 buck missed strobe 2");
  a_backup_hold_on: assert property (powerDown && sealSync_ff && railEn[1:0] == 2'h3
      |=> railEn[1:0] == 2'h3)
    else $error("backup buck turned off after seal broken");
  a_linreg_strobe: assert property (strobeFire && !powerDown &&
      linearRegStrobeSel == strobeIdx && strobeIdx >= 4'h3 && strobeIdx <= 4'ha |=> railEn[3])
    else $error("regulator missed its strobe");
  a_switch_ignored: assert property (strobeFire &&
      (lvSwitchStrobeSel < 4'h3 || lvSwitchStrobeSel > 4'ha) |=> $stable(railEn[2]))
    else $error("unsequenced switch moved");

  c_unlocked_write: cover property (regWrEn && unlockOk && regAddr == 8'h25);
  c_seal_skip: cover property (strobeFire && sealSync_ff && strobeIdx == 4'h1);
  c_power_down_off: cover property (strobeFire && powerDown && railEn[3] ##1 !railEn[3]);

endmodule : rail_strobe_assignment_regs

/* host_reg_model.sv */
// Host-side model issuing byte accesses on the internal register port
`timescale 1ns/1ps
module host_reg_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic            unlockOk
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    unlockOk  = 1'b0;
  end

  // ==========================================================
  // Access tasks
  // The password sequence is abstracted to one level change
  task automatic setUnlock(input logic on);
    @(negedge clk);
    unlockOk = on;
  endtask : setUnlock

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    // Stale data is inverted so a late capture cannot pass by luck
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    d       = regRdData;
  endtask : rd
endmodule : host_reg_model

/* rail_strobe_assignment_regs_bench.sv */
// Self-checking bench for the rail strobe assignment registers
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, a); end end
module rail_strobe_assignment_regs_bench;
  logic       clk, sysRst, sealFlag, strobeFire, powerDown, hit;
  logic       regWrEn, regRdEn, unlockOk, regWrRejected, strobeDone, strobeSkipped;
  logic [3:0] strobeIdx, railEn, swSel, lrSel, code;
  logic [1:0] b18Sel, b10Sel;
  logic [7:0] regAddr, regWrData, regRdData, gpSel, rdVal;
  logic [7:0] rstTab [4] = '{8'h12, 8'ha7, 8'h35, 8'h00};
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;

  rail_strobe_assignment_regs i_dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .unlockOk(unlockOk),
    .regRdData(regRdData), .regWrRejected(regWrRejected), .freshnessSealFlag(sealFlag),
    .strobeFire(strobeFire), .strobeIdx(strobeIdx), .powerDown(powerDown),
    .railEn(railEn), .strobeDone(strobeDone), .strobeSkipped(strobeSkipped),
    .backup1v8StrobeSel(b18Sel), .backup1v0StrobeSel(b10Sel),
    .lvSwitchStrobeSel(swSel), .linearRegStrobeSel(lrSel), .gpOutputStrobeSelect(gpSel));

  host_reg_model i_host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .unlockOk(unlockOk));

  // ==========================================================
  // Clock, timeout and verdict
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================================
  // Strobe generator stand-in
  task automatic fire(input logic [3:0] idx, input logic pd);
    @(negedge clk);
    strobeFire = 1'b1;
    strobeIdx  = idx;
    powerDown  = pd;
    @(negedge clk);
    strobeFire = 1'b0;
  endtask : fire

  // ==========================================================
  // Test sequence
  initial begin
    sysRst     = 1'b1;
    sealFlag   = 1'b0;
    strobeFire = 1'b0;
    strobeIdx  = 4'h0;
    powerDown  = 1'b0;
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    `CHK("b18Sel", 2'h1, b18Sel)
    `CHK("b10Sel", 2'h2, b10Sel)
    `CHK("gpSel", 8'h35, gpSel)
    for (int i = 0; i < 4; i++) begin
      i_host.rd(8'h24 + i[7:0], rdVal);
      `CHK("rdVal", rstTab[i], rdVal)
    end
    fire(4'h1, 1'b0);
    `CHK("strobeDone", 1'b1, strobeDone)
    fire(4'h2, 1'b0);
    `CHK("railEnUp", 2'b11, railEn[1:0])
    // Locked write must bounce and leave the fields alone
    i_host.wr(8'h25, 8'h3b);
    `CHK("regWrRejected", 1'b1, regWrRejected)
    `CHK("swSel", 4'ha, swSel)
    i_host.setUnlock(1'b1);
    i_host.wr(8'h24, 8'hff);
    i_host.rd(8'h24, rdVal);
    `CHK("rdMask", 8'h33, rdVal)
    i_host.wr(8'h26, 8'h5c);
    i_host.rd(8'h26, rdVal);
    `CHK("rdGpo", 8'h5c, rdVal)
    `CHK("gpSelWr", 8'h5c, gpSel)
    fire(4'h1, 1'b1);
    `CHK("railEnCode3", 2'b11, railEn[1:0])
    i_host.wr(8'h24, 8'h21);
    fire(4'h2, 1'b1);
    `CHK("railEnDown", 2'b10, railEn[1:0])
    fire(4'h2, 1'b0);
    `CHK("railEnBoth", 2'b11, railEn[1:0])
    // Broken seal with both bucks on: power-down strobes 1 and 2 skipped, bucks kept on
    sealFlag = 1'b1;
    repeat (3) @(negedge clk);
    fire(4'h1, 1'b1);
    `CHK("strobeSkipped", 1'b1, strobeSkipped)
    `CHK("strobeDoneSkip", 1'b0, strobeDone)
    `CHK("railEnHeld", 2'b11, railEn[1:0])
    fire(4'h2, 1'b1);
    `CHK("railEnSkip", 2'b11, railEn[1:0])
    for (int c = 0; c < 16; c++) begin
      code = c[3:0];
      hit  = (code >= 4'h3 && code <= 4'ha);
      i_host.wr(8'h25, {code, code});
      `CHK("lrSel", code, lrSel)
      fire(hit ? code : 4'ha, 1'b0);
      `CHK("railEnNib", {hit, hit}, railEn[3:2])
      fire(hit ? code : 4'ha, 1'b1);
      `CHK("railEnOff", 2'b00, railEn[3:2])
    end
    // Mid-run reset: rails drop and the fields return to their reset values
    sysRst = 1'b1;
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    `CHK("railEnRst", 4'h0, railEn)
    i_host.rd(8'h25, rdVal);
    `CHK("rdRst", 8'ha7, rdVal)
    conclude();
  end
endmodule : rail_strobe_assignment_regs_bench
